// ---- verilog/lpm_pkg.sv ----
// Shared types and constants for the low-power mode control block.
package lpm_pkg;

    // Command bus pins, sampled together on a link clock edge.
    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_bus_t;

    // Every pin that arrives from the memory controller.
    typedef struct packed {
        logic     ck;
        logic     cke;
        logic     reset_n;
        logic     odt;
        cmd_bus_t cmd;
    } link_pins_t;

    localparam int LINK_W = $bits(link_pins_t);

    // Self-refresh rate actually applied by the refresh timer.
    typedef enum logic [1:0] {
        RATE_NORMAL,
        RATE_REDUCED,
        RATE_EXTENDED
    } sr_rate_t;

    // Self-refresh temperature mode field codes.
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_REDUCED  = 2'h1;
    localparam logic [1:0] MODE_EXTENDED = 2'h2;
    localparam logic [1:0] MODE_AUTO     = 2'h3;

    // Case temperature limits in degrees Celsius.
    localparam logic [7:0] TEMP_REDUCED_MAX = 8'h2D;
    localparam logic [7:0] TEMP_NORMAL_MAX  = 8'h55;

    localparam logic [2:0] PARK_OFF = 3'h0;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // Counts in link clock edges.
    localparam int         CNT_W     = 4;
    localparam logic [3:0] BLANK_NCK = 4'h4;
    localparam logic [3:0] CKE_NCK   = 4'h3;
    localparam logic [3:0] XP_NCK    = 4'h4;
    localparam logic [3:0] CNT_MAX   = 4'hF;

    // Exit latency floor in time, converted to block clock cycles.
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         TXP_NS        = 6;
    localparam int         XP_CYC_INT    =
        (TXP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] XP_CYC        =
        (XP_CYC_INT < 1) ? 4'h1 : 4'(XP_CYC_INT);

endpackage

// ---- verilog/pin_sync.sv ----
// Two-stage synchroniser for controller pins with rising-edge detect.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Raw pins and synchronised view
    input  wire logic [W-1:0] din,
    output wire logic [W-1:0] level,
    output wire logic [W-1:0] rise
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Only the second stage and beyond feed logic.
    assign level = s2_ff;
    assign rise  = s2_ff & ~s3_ff;
endmodule

// ---- verilog/sr_rate_select.sv ----
// Self-refresh rate selection from the temperature mode field.
`timescale 1ns/1ps
module sr_rate_select (
    // Latched mode and die temperature
    input  wire logic [1:0]       mode,
    input  wire logic [7:0]       temp_c,
    // Selected rate
    output lpm_pkg::sr_rate_t     rate
);
    function automatic lpm_pkg::sr_rate_t rate_of(input logic [1:0] m,
                                                  input logic [7:0] t);
        lpm_pkg::sr_rate_t r;
        r = lpm_pkg::RATE_NORMAL;
        case (m)
            lpm_pkg::MODE_NORMAL: begin
                r = lpm_pkg::RATE_NORMAL;
            end
            lpm_pkg::MODE_REDUCED: begin
                r = lpm_pkg::RATE_REDUCED;
            end
            lpm_pkg::MODE_EXTENDED: begin
                r = lpm_pkg::RATE_EXTENDED;
            end
            default: begin
                // Automatic: slower when cold, faster when hot.
                if (t <= lpm_pkg::TEMP_REDUCED_MAX) begin
                    r = lpm_pkg::RATE_REDUCED;
                end else if (t <= lpm_pkg::TEMP_NORMAL_MAX) begin
                    r = lpm_pkg::RATE_NORMAL;
                end else begin
                    r = lpm_pkg::RATE_EXTENDED;
                end
            end
        endcase
        return r;
    endfunction

    assign rate = rate_of(mode, temp_c);
endmodule

// ---- verilog/ddr4_low_power_mode_control.sv ----
// Power-down and self-refresh rate control of the memory device.
// Contract
// - Mode field 11 turns on automatic self-refresh rate management.
// - Automatic mode: slower refresh when cold, faster when hot.
// - Field 00 normal, 01 reduced, 10 extended, 11 automatic.
// - Enter power-down on clock-enable low with a deselect.
// - Activation, precharge, refresh finish before low current is reached.
// - All banks closed: precharge power-down; any open: active power-down.
// - Entry turns off buffers except clock, clock-enable and reset.
// - Buffer bit 0 keeps termination input on; 1 drops it and nominal.
// - Park termination stays on in power-down when set nonzero.
// - Deselects through blanking; command receivers off only after it.
// - Loop on: both power-down kinds use fast exit after the latency.
// - The delay-locked loop stays enabled in both power-down kinds.
// - Reset low during power-down leaves it at once for reset.
// - Exit on clock-enable high; valid command only after exit latency.
`timescale 1ns/1ps
module ddr4_low_power_mode_control #(
    parameter logic [3:0] BLANK_NCK = lpm_pkg::BLANK_NCK,
    parameter logic [3:0] CKE_NCK   = lpm_pkg::CKE_NCK,
    parameter logic [3:0] XP_NCK    = lpm_pkg::XP_NCK,
    parameter logic [3:0] XP_CYC    = lpm_pkg::XP_CYC
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Controller pins
    input  wire logic              ck,
    input  wire logic              cke,
    input  wire logic              reset_n,
    input  wire logic              odt_in,
    input  wire lpm_pkg::cmd_bus_t cmd_in,
    // Mode register fields
    input  wire logic [1:0]        sr_temp_mode,
    input  wire logic [2:0]        park_termination,
    input  wire logic              odt_buffer_off,
    input  wire logic              nominal_termination,
    // Core state
    input  wire logic [7:0]        temp_c,
    input  wire logic              bank_open,
    input  wire logic              ops_busy,
    input  wire logic              dll_locked,
    input  wire logic              sr_active,
    // Power-down status
    output logic                   power_down_ff,
    output logic                   precharge_pd_ff,
    output logic                   active_pd_ff,
    output logic                   pd_current_ok_ff,
    output logic                   exit_ready_ff,
    output logic                   in_reset_ff,
    output logic                   dll_enabled_ff,
    output logic                   dll_reset_needed_ff,
    // Buffer and termination control
    output logic                   in_buffers_on_ff,
    output logic                   out_buffers_on_ff,
    output logic                   cmd_receivers_on_ff,
    output logic                   odt_buffer_on_ff,
    output logic                   nom_term_on_ff,
    output logic                   park_term_on_ff,
    // Accepted commands and refresh rate
    output logic                   cmd_accept_ff,
    output lpm_pkg::cmd_bus_t      cmd_word_ff,
    output lpm_pkg::sr_rate_t      sr_rate_ff
);
    typedef enum logic [2:0] {
        ST_RESET,
        ST_IDLE,
        ST_BLANK,
        ST_PD,
        ST_EXIT
    } pd_state_t;
    pd_state_t            state_ff;
    pd_state_t            nxt_state;
    logic [3:0]           edge_cnt_ff;
    logic [3:0]           low_cnt_ff;
    logic [3:0]           cyc_cnt_ff;
    logic [1:0]           sr_mode_ff;
    logic                 sr_active_d_ff;
    lpm_pkg::link_pins_t  pins_raw;
    lpm_pkg::link_pins_t  pins_s;
    lpm_pkg::link_pins_t  rise_s;
    logic [lpm_pkg::LINK_W-1:0] pins_lvl;
    logic [lpm_pkg::LINK_W-1:0] pins_rise;
    lpm_pkg::sr_rate_t    rate_w;
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        return (v == lpm_pkg::CNT_MAX) ? v : 4'(v + 4'h1);
    endfunction
    assign pins_raw = '{ck: ck, cke: cke, reset_n: reset_n, odt: odt_in,
                        cmd: cmd_in};
    pin_sync #(
        .W     (lpm_pkg::LINK_W)
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   (pins_raw),
        .level (pins_lvl),
        .rise  (pins_rise)
    );
    assign pins_s = lpm_pkg::link_pins_t'(pins_lvl);
    assign rise_s = lpm_pkg::link_pins_t'(pins_rise);
    // Decoded link events.
    wire ck_rise    = rise_s.ck;
    wire deselect   = pins_s.cmd.cs_n;
    wire pin_reset  = !pins_s.reset_n;
    wire enter_pd   = ck_rise && !pins_s.cke && deselect;
    wire leave_pd   = ck_rise && pins_s.cke && (low_cnt_ff >= CKE_NCK);
    wire blank_done = ck_rise && (edge_cnt_ff >= 4'(BLANK_NCK - 4'h1));
    wire xp_done    = (edge_cnt_ff >= XP_NCK) && (cyc_cnt_ff >= XP_CYC);
    wire state_chg  = (nxt_state != state_ff);
    wire sr_start   = sr_active && !sr_active_d_ff;
    // Next-state view used by the registered outputs.
    wire nxt_in_pd  = (nxt_state == ST_BLANK) || (nxt_state == ST_PD);
    wire nxt_odt_on = !(nxt_in_pd && odt_buffer_off);
    wire nxt_live   = (nxt_state != ST_RESET);
    always_comb begin
        nxt_state = state_ff;
        if (pin_reset) begin
            nxt_state = ST_RESET;
        end else begin
            case (state_ff)
                ST_RESET: begin
                    nxt_state = ST_IDLE;
                end
                ST_IDLE: begin
                    if (enter_pd) begin
                        nxt_state = ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    // Receivers stay up until blanking has run out.
                    if (blank_done) begin
                        nxt_state = ST_PD;
                    end
                end
                ST_PD: begin
                    // A high clock-enable before the pulse floor is ignored.
                    if (leave_pd) begin
                        nxt_state = ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    // Same fast exit for active and precharge power-down.
                    if (xp_done) begin
                        nxt_state = ST_IDLE;
                    end
                end
                default: begin
                    nxt_state = ST_RESET;
                end
            endcase
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff    <= ST_RESET;
            edge_cnt_ff <= 4'h0;
            low_cnt_ff  <= 4'h0;
            cyc_cnt_ff  <= 4'h0;
        end else begin
            state_ff    <= nxt_state;
            edge_cnt_ff <= state_chg ? 4'h0 :
                           (ck_rise ? sat_inc(edge_cnt_ff) : edge_cnt_ff);
            cyc_cnt_ff  <= state_chg ? 4'h0 : sat_inc(cyc_cnt_ff);
            low_cnt_ff  <= !nxt_in_pd ? 4'h0 :
                           (ck_rise ? sat_inc(low_cnt_ff) : low_cnt_ff);
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            power_down_ff    <= 1'b0;
            precharge_pd_ff  <= 1'b0;
            active_pd_ff     <= 1'b0;
            pd_current_ok_ff <= 1'b0;
            exit_ready_ff    <= 1'b0;
            in_reset_ff      <= 1'b1;
            dll_enabled_ff   <= 1'b0;
        end else begin
            power_down_ff    <= nxt_in_pd;
            precharge_pd_ff  <= nxt_in_pd && !ops_busy && !bank_open;
            active_pd_ff     <= nxt_in_pd && !ops_busy && bank_open;
            pd_current_ok_ff <= nxt_in_pd && !ops_busy;
            exit_ready_ff    <= (nxt_state == ST_IDLE);
            in_reset_ff      <= !nxt_live;
            dll_enabled_ff   <= nxt_live;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_buffers_on_ff    <= 1'b0;
            out_buffers_on_ff   <= 1'b0;
            cmd_receivers_on_ff <= 1'b0;
            odt_buffer_on_ff    <= 1'b0;
            nom_term_on_ff      <= 1'b0;
            park_term_on_ff     <= 1'b0;
        end else begin
            in_buffers_on_ff    <= nxt_live && !nxt_in_pd;
            out_buffers_on_ff   <= nxt_live && !nxt_in_pd;
            cmd_receivers_on_ff <= nxt_live && (nxt_state != ST_PD);
            odt_buffer_on_ff    <= nxt_live && nxt_odt_on;
            nom_term_on_ff      <= nxt_live && nxt_odt_on &&
                                   nominal_termination && pins_s.odt;
            park_term_on_ff     <= nxt_live &&
                                   (park_termination != lpm_pkg::PARK_OFF);
        end
    end
    // Set wins over clear so an unlocked entry is never forgotten.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dll_reset_needed_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && enter_pd && !dll_locked) begin
            dll_reset_needed_ff <= 1'b1;
        end else if (state_ff == ST_IDLE && dll_locked) begin
            dll_reset_needed_ff <= 1'b0;
        end
    end
    // Commands are only decoded while the receivers are live.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_accept_ff <= 1'b0;
            cmd_word_ff   <= '1;
        end else begin
            cmd_accept_ff <= (state_ff == ST_IDLE) && !pin_reset &&
                             ck_rise && pins_s.cke && !deselect;
            if ((state_ff == ST_IDLE) && ck_rise && pins_s.cke) begin
                cmd_word_ff <= pins_s.cmd;
            end
        end
    end
    // The manual mode is caught once at entry; later changes wait.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sr_active_d_ff <= 1'b0;
            sr_mode_ff     <= lpm_pkg::MODE_RESET;
            sr_rate_ff     <= lpm_pkg::RATE_NORMAL;
        end else begin
            sr_active_d_ff <= sr_active;
            if (sr_start) begin
                sr_mode_ff <= sr_temp_mode;
            end
            sr_rate_ff     <= rate_w;
        end
    end

    sr_rate_select u_rate (
        .mode   (sr_mode_ff),
        .temp_c (temp_c),
        .rate   (rate_w)
    );
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_entry;
        (state_ff == ST_IDLE) && !pin_reset && enter_pd
            |=> (state_ff == ST_BLANK) ##1 power_down_ff;
    endproperty
    a_entry: assert property (p_entry)
        else $error("power-down entry not taken");
    property p_blank;
        $fell(cmd_receivers_on_ff) && !in_reset_ff
            |-> $past(state_ff == ST_BLANK, 2) && power_down_ff;
    endproperty
    a_blank: assert property (p_blank)
        else $error("receivers dropped outside blanking");
    property p_buffers;
        power_down_ff |-> !in_buffers_on_ff && !out_buffers_on_ff;
    endproperty
    a_buffers: assert property (p_buffers)
        else $error("buffers on during power-down");
    property p_odt_off;
        power_down_ff && $past(odt_buffer_off)
            |-> !odt_buffer_on_ff && !nom_term_on_ff;
    endproperty
    a_odt_off: assert property (p_odt_off)
        else $error("termination input not dropped");
    property p_odt_on;
        power_down_ff && !$past(odt_buffer_off) |-> odt_buffer_on_ff;
    endproperty
    a_odt_on: assert property (p_odt_on)
        else $error("termination input dropped");
    property p_park;
        power_down_ff
            |-> park_term_on_ff == ($past(park_termination) != 3'h0);
    endproperty
    a_park: assert property (p_park)
        else $error("park termination wrong in power-down");
    property p_reset;
        pin_reset |=> in_reset_ff && !power_down_ff && !exit_ready_ff;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not override power-down");
    property p_exit;
        (state_ff == ST_PD) && !pin_reset && leave_pd
            |=> (state_ff == ST_EXIT) ##1 !exit_ready_ff;
    endproperty
    a_exit: assert property (p_exit)
        else $error("power-down exit not taken");
    property p_xp;
        $rose(exit_ready_ff) && $past(state_ff == ST_EXIT)
            |-> $past(edge_cnt_ff >= XP_NCK);
    endproperty
    a_xp: assert property (p_xp)
        else $error("ready before exit latency");
    property p_kind;
        power_down_ff && $past(!ops_busy)
            |-> (precharge_pd_ff == $past(!bank_open)) &&
                (active_pd_ff == $past(bank_open));
    endproperty
    a_kind: assert property (p_kind)
        else $error("wrong power-down kind");
    property p_current;
        pd_current_ok_ff |-> power_down_ff && !$past(ops_busy);
    endproperty
    a_current: assert property (p_current)
        else $error("low current before operations done");
    property p_dll;
        power_down_ff |-> dll_enabled_ff;
    endproperty
    a_dll: assert property (p_dll)
        else $error("loop disabled in power-down");
    property p_ignore;
        power_down_ff |-> !cmd_accept_ff;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("command accepted in power-down");
    property p_auto;
        (sr_mode_ff == 2'h3) && (temp_c > 8'h55) |=> sr_rate_ff == 2'h2;
    endproperty
    a_auto: assert property (p_auto)
        else $error("hot automatic rate not extended");
endmodule

// ---- tb/ddr_ctrl_model.sv ----
// Memory controller model that drives the link pins of the device.
`timescale 1ns/1ps
module ddr_ctrl_model (
    // Block clock, used only to time pin changes
    input  wire logic        clock,
    // Link pins toward the device
    output logic              ck,
    output logic              cke,
    output logic              reset_n,
    output logic              odt,
    output lpm_pkg::cmd_bus_t cmd
);
    // The link clock runs free, because power-down needs a stable clock.
    initial begin
        cke = 1'b1;
        reset_n = 1'b0;
        odt = 1'b1;
        cmd = 5'h1F;
        ck = 1'b0;
        #37;
        forever #160 ck = ~ck;
    end

    task automatic rise(input int n);
        repeat (n) @(posedge ck);
    endtask

    // Pins change after a falling link edge, well before the next rise.
    task automatic drive(input logic c, input logic [4:0] w, input int n);
        @(negedge ck);
        @(posedge clock);
        cke <= c;
        cmd <= w;
        rise(n);
    endtask

    // Command pins are don't-care in power-down, so hold cs_n low and toggle the rest each edge.
    task automatic garble(input int n);
        repeat (n) begin
            @(negedge ck);
            @(posedge clock);
            cke <= 1'b0;
            cmd <= {1'b0, ~cmd[3:0]};
            @(posedge ck);
        end
    endtask

    task automatic set_reset(input logic v);
        @(posedge clock);
        reset_n <= v;
    endtask
endmodule

// ---- tb/tb_ddr4_low_power_mode_control.sv ----
// Self-checking testbench for the low-power mode control block.
`timescale 1ns/1ps
module tb_ddr4_low_power_mode_control;
    localparam logic [4:0] DES = 5'h1F;
    localparam logic [4:0] ACT = 5'h07;
    localparam logic [4:0] NOP = 5'h0F;
    logic              clock, rst, ck, cke, reset_n, odt_in;
    lpm_pkg::cmd_bus_t cmd_in, cmd_word_ff;
    lpm_pkg::sr_rate_t sr_rate_ff;
    logic [1:0]        sr_temp_mode;
    logic [2:0]        park_termination;
    logic [7:0]        temp_c;
    logic              odt_buffer_off, nominal_termination, bank_open;
    logic              ops_busy, dll_locked, sr_active, power_down_ff;
    logic              precharge_pd_ff, active_pd_ff, pd_current_ok_ff;
    logic              exit_ready_ff, in_reset_ff, dll_enabled_ff;
    logic              dll_reset_needed_ff, in_buffers_on_ff;
    logic              out_buffers_on_ff, cmd_receivers_on_ff;
    logic              odt_buffer_on_ff, nom_term_on_ff, park_term_on_ff;
    logic              cmd_accept_ff;
    int                miscompares, n_tests, accepts, cycles;
    logic [1:0]        modes [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [7:0]        temps [6] = '{8'h32, 8'h32, 8'h32, 8'h1E, 8'h3C, 8'h64};
    logic [1:0]        rates [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h2};

    ddr_ctrl_model ddr_ctrl_model_i (.clock(clock), .ck(ck), .cke(cke),
        .reset_n(reset_n), .odt(odt_in), .cmd(cmd_in));

    ddr4_low_power_mode_control ddr4_low_power_mode_control_i (
        .clock(clock), .rst(rst), .ck(ck), .cke(cke), .reset_n(reset_n),
        .odt_in(odt_in), .cmd_in(cmd_in), .sr_temp_mode(sr_temp_mode),
        .park_termination(park_termination),
        .odt_buffer_off(odt_buffer_off),
        .nominal_termination(nominal_termination), .temp_c(temp_c),
        .bank_open(bank_open), .ops_busy(ops_busy),
        .dll_locked(dll_locked), .sr_active(sr_active),
        .power_down_ff(power_down_ff), .precharge_pd_ff(precharge_pd_ff),
        .active_pd_ff(active_pd_ff), .pd_current_ok_ff(pd_current_ok_ff),
        .exit_ready_ff(exit_ready_ff), .in_reset_ff(in_reset_ff),
        .dll_enabled_ff(dll_enabled_ff),
        .dll_reset_needed_ff(dll_reset_needed_ff),
        .in_buffers_on_ff(in_buffers_on_ff),
        .out_buffers_on_ff(out_buffers_on_ff),
        .cmd_receivers_on_ff(cmd_receivers_on_ff),
        .odt_buffer_on_ff(odt_buffer_on_ff),
        .nom_term_on_ff(nom_term_on_ff), .park_term_on_ff(park_term_on_ff),
        .cmd_accept_ff(cmd_accept_ff), .cmd_word_ff(cmd_word_ff),
        .sr_rate_ff(sr_rate_ff));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A link edge needs up to three clocks to be seen and registered.
    task automatic settle();
        repeat (6) @(posedge clock);
        #1;
    endtask

    always @(posedge clock) begin
        if (cmd_accept_ff === 1'b1) begin
            accepts <= accepts + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        {miscompares, n_tests, accepts, cycles} = '0;
        rst = 1'b1;
        {sr_temp_mode, park_termination, temp_c} = '0;
        {odt_buffer_off, bank_open, ops_busy, sr_active} = '0;
        {nominal_termination, dll_locked} = 2'h3;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        settle();
        check("in_reset", in_reset_ff, 8'h1);
        check("cmd_word", cmd_word_ff, 8'h1F);
        ddr_ctrl_model_i.set_reset(1'b1);
        settle();
        check("exit_ready", exit_ready_ff, 8'h1);
        ddr_ctrl_model_i.drive(1'b1, ACT, 1);
        settle();
        check("accepts", accepts, 8'h1);
        check("cmd_word", cmd_word_ff, ACT);
        ddr_ctrl_model_i.drive(1'b0, ACT, 2);
        settle();
        check("pd_without_des", power_down_ff, 8'h0);
        ddr_ctrl_model_i.drive(1'b1, DES, 1);
        // Active power-down while an activation is still running.
        bank_open <= 1'b1;
        ops_busy <= 1'b1;
        park_termination <= 3'h2;
        ddr_ctrl_model_i.drive(1'b0, DES, 1);
        settle();
        check("power_down", power_down_ff, 8'h1);
        check("in_buffers", in_buffers_on_ff, 8'h0);
        check("out_buffers", out_buffers_on_ff, 8'h0);
        check("receivers_blank", cmd_receivers_on_ff, 8'h1);
        check("pd_current", pd_current_ok_ff, 8'h0);
        check("active_pd", active_pd_ff, 8'h0);
        check("dll_enabled", dll_enabled_ff, 8'h1);
        check("park_term", park_term_on_ff, 8'h1);
        check("odt_buffer", odt_buffer_on_ff, 8'h1);
        check("nom_term", nom_term_on_ff, 8'h1);
        ddr_ctrl_model_i.drive(1'b1, DES, 1);
        settle();
        check("early_exit", power_down_ff, 8'h1);
        ddr_ctrl_model_i.garble(6);
        ops_busy <= 1'b0;
        settle();
        check("receivers_off", cmd_receivers_on_ff, 8'h0);
        // The first command stood for two link edges, so two were taken.
        check("accepts_pd", accepts, 8'h2);
        check("pd_current", pd_current_ok_ff, 8'h1);
        check("active_pd_done", active_pd_ff, 8'h1);
        ddr_ctrl_model_i.drive(1'b1, DES, 2);
        settle();
        check("exit_pd", power_down_ff, 8'h0);
        check("exit_latency", exit_ready_ff, 8'h0);
        ddr_ctrl_model_i.rise(4);
        settle();
        check("exit_done", exit_ready_ff, 8'h1);
        // Precharge power-down, loop unlocked, termination buffer off.
        bank_open <= 1'b0;
        dll_locked <= 1'b0;
        odt_buffer_off <= 1'b1;
        ddr_ctrl_model_i.drive(1'b0, DES, 1);
        settle();
        check("precharge_pd", precharge_pd_ff, 8'h1);
        check("odt_buffer_off", odt_buffer_on_ff, 8'h0);
        check("nom_term_off", nom_term_on_ff, 8'h0);
        check("dll_reset", dll_reset_needed_ff, 8'h1);
        ddr_ctrl_model_i.set_reset(1'b0);
        settle();
        check("reset_in_pd", in_reset_ff, 8'h1);
        check("pd_left", power_down_ff, 8'h0);
        ddr_ctrl_model_i.drive(1'b1, DES, 0);
        ddr_ctrl_model_i.set_reset(1'b1);
        settle();
        check("after_reset", exit_ready_ff, 8'h1);
        for (int i = 0; i < 6; i++) begin
            sr_active <= 1'b0;
            sr_temp_mode <= modes[i];
            temp_c <= temps[i];
            @(posedge clock);
            sr_active <= 1'b1;
            settle();
            check("sr_rate", sr_rate_ff, rates[i]);
            sr_temp_mode <= ~modes[i];
            settle();
            check("sr_rate_fixed", sr_rate_ff, rates[i]);
        end
        sr_active <= 1'b0;
        ddr_ctrl_model_i.drive(1'b1, NOP, 2);
        settle();
        check("nop_exit", cmd_word_ff, NOP);
        check("nop_count", accepts, 8'h4);
        stop_test();
    end
endmodule
